// ===== src/pml_phy_regs.sv
// per-port phy mmd indirect access, capability status and remote loopback
`timescale 1ns/1ns
`default_nettype none
`include "pml_defines.svh"

module pml_phy_regs (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// management register port
	input wire logic [4:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [15:0] i_reg_wdata,
	output logic [15:0] o_reg_rdata,
	output logic o_reg_rvalid,
	// port flavour: high for a media-independent interface port
	input wire logic i_port_is_mii,
	// integrated phy line side
	input wire logic [7:0] i_phy_rx_data,
	input wire logic i_phy_rx_dv,
	output logic [7:0] o_phy_tx_data,
	output logic o_phy_tx_en,
	// media-independent interface side
	input wire logic [7:0] i_mii_txd,
	input wire logic i_mii_tx_en,
	output logic [7:0] o_mii_rxd,
	output logic o_mii_rx_dv,
	// switch fabric side
	output logic [7:0] o_fab_rx_data,
	output logic o_fab_rx_dv,
	input wire logic [7:0] i_fab_tx_data,
	input wire logic i_fab_tx_en,
	// loopback state
	output logic o_loopback
);

	pml_pkg::pml_mode_t mode_q;
	logic [4:0] dev_q;
	logic [8:0] setup_rsv_q;
	logic [15:0] ptr_q;
	logic [15:0] loop_q;
	logic [15:0] rd_val_q;
	logic rd_mem_q;
	logic rd_pend_q;
	logic wr_setup, wr_data, wr_loop, rd_data, rd_loop, data_mode;
	logic [15:0] reg_view;
	logic [7:0] in_data;
	logic in_dv;

	pml_mem_if mif ();

	// ========================================
	// address of an mmd register inside the backing store
	// devices above seven and registers above 31 alias onto others
	function automatic logic [`PML_MEM_AW-1:0] mem_index(
		input logic [4:0] dev,
		input logic [15:0] addr
	);
		mem_index = {dev[`PML_MEM_DEV_BITS-1:0],
			addr[`PML_MEM_REG_BITS-1:0]};
	endfunction

	// post-increment by one, wrapping at 16 bits
	function automatic logic [15:0] next_addr(input logic [15:0] addr);
		next_addr = addr + `PML_ONE16;
	endfunction

	// ========================================
	// access decode; a write wins over a read in the same cycle
	// a read dropped this way gets no answer at all
	assign wr_setup = i_reg_wr && (i_reg_addr == `PML_REG_SETUP);
	assign wr_data = i_reg_wr && (i_reg_addr == `PML_REG_DATA);
	assign wr_loop = i_reg_wr && (i_reg_addr == `PML_REG_LOOP);
	assign rd_data = i_reg_rd && !i_reg_wr && (i_reg_addr == `PML_REG_DATA);
	assign rd_loop = i_reg_rd && !i_reg_wr && (i_reg_addr == `PML_REG_LOOP);
	assign data_mode = (mode_q != pml_pkg::PML_MODE_REG);

	// ========================================
	// setup register: mode, reserved bits and device address
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mode_q <= pml_pkg::PML_MODE_REG;
			// fields are shifted out of the packed reset word
			setup_rsv_q <= 9'(`PML_SETUP_RST >> `PML_SETUP_RSV_LO);
			dev_q <= 5'(`PML_SETUP_RST >> `PML_DEV_LO);
		end else if (wr_setup) begin
			mode_q <= pml_pkg::pml_mode_t'(
				i_reg_wdata[`PML_MODE_HI:`PML_MODE_LO]);
			setup_rsv_q <= i_reg_wdata
				[`PML_SETUP_RSV_HI:`PML_SETUP_RSV_LO];
			dev_q <= i_reg_wdata[`PML_DEV_HI:`PML_DEV_LO];
		end
	end

	// ========================================
	// mmd register address pointer
	// a data write in mode 00 reloads it instead of touching the store
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ptr_q <= `PML_DATA_RST;
		end else if (wr_data) begin
			case (mode_q)
				pml_pkg::PML_MODE_REG: ptr_q <= i_reg_wdata;
				pml_pkg::PML_MODE_DATA: ptr_q <= ptr_q;
				pml_pkg::PML_MODE_INC_RW: ptr_q <= next_addr(ptr_q);
				pml_pkg::PML_MODE_INC_WR: ptr_q <= next_addr(ptr_q);
				default: ptr_q <= ptr_q;
			endcase
		end else if (rd_data && (mode_q == pml_pkg::PML_MODE_INC_RW)) begin
			ptr_q <= next_addr(ptr_q);
		end
	end

	// ========================================
	// backing store access in data modes, at the pre-increment address
	assign mif.we = wr_data && data_mode;
	assign mif.addr = mem_index(dev_q, ptr_q);
	assign mif.wdata = i_reg_wdata;

	pml_mmd_mem u_mem (
		.i_clk(i_clk),
		.m(mif.mem)
	);

	// ========================================
	// remote loopback register; bit 1 clears on read, bit 0 reads zero
	// the reserved bits keep whatever software last wrote
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			loop_q <= `PML_LOOP_RST;
		end else if (wr_loop) begin
			loop_q <= i_reg_wdata & `PML_LOOP_WMASK;
		end else if (rd_loop) begin
			loop_q[`PML_LOOP_RC_BIT] <= 1'b0;
		end
	end

	// ========================================
	// read mux for the registers held in flops
	// data reads in a data mode are swapped for store output later
	always_comb begin
		reg_view = `PML_ZERO16;
		case (i_reg_addr)
			`PML_REG_SETUP: reg_view = {mode_q, setup_rsv_q, dev_q};
			`PML_REG_DATA: reg_view = ptr_q;
			`PML_REG_CAP: reg_view = `PML_CAP_VALUE;
			`PML_REG_LOOP: reg_view = loop_q;
			default: reg_view = `PML_ZERO16;
		endcase
	end

	// ========================================
	// read pipeline: two cycles from request to answer
	// the store answers one edge after the request, still for the
	// address before any post-increment
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rd_pend_q <= 1'b0;
			rd_mem_q <= 1'b0;
			rd_val_q <= `PML_ZERO16;
		end else begin
			rd_pend_q <= i_reg_rd && !i_reg_wr;
			rd_mem_q <= rd_data && data_mode;
			rd_val_q <= reg_view;
		end
	end

	// answer register; rdata holds until the next answer
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_reg_rdata <= `PML_ZERO16;
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= rd_pend_q;
			if (rd_pend_q) begin
				o_reg_rdata <= rd_mem_q ? mif.rdata : rd_val_q;
			end
		end
	end

	// ========================================
	// ingress selection by port flavour
	// only the flavour strapped on this port feeds the fabric
	assign in_data = i_port_is_mii ? i_mii_txd : i_phy_rx_data;
	assign in_dv = i_port_is_mii ? i_mii_tx_en : i_phy_rx_dv;

	// ========================================
	// datapath: loop ingress back out, or forward through the fabric
	// a change of mode acts at once and may cut a frame in flight
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_phy_tx_data <= 8'h00;
			o_phy_tx_en <= 1'b0;
			o_mii_rxd <= 8'h00;
			o_mii_rx_dv <= 1'b0;
			o_fab_rx_data <= 8'h00;
			o_fab_rx_dv <= 1'b0;
			o_loopback <= 1'b0;
		end else begin
			o_loopback <= loop_q[`PML_LOOP_BIT];
			if (loop_q[`PML_LOOP_BIT]) begin
				// egress of the same port carries its own ingress
				o_phy_tx_data <= i_phy_rx_data;
				o_phy_tx_en <= i_phy_rx_dv && !i_port_is_mii;
				o_mii_rxd <= i_mii_txd;
				o_mii_rx_dv <= i_mii_tx_en && i_port_is_mii;
				o_fab_rx_data <= 8'h00;
				o_fab_rx_dv <= 1'b0;
			end else begin
				o_phy_tx_data <= i_fab_tx_data;
				o_phy_tx_en <= i_fab_tx_en && !i_port_is_mii;
				o_mii_rxd <= i_fab_tx_data;
				o_mii_rx_dv <= i_fab_tx_en && i_port_is_mii;
				o_fab_rx_data <= in_data;
				o_fab_rx_dv <= in_dv;
			end
		end
	end

endmodule

`default_nettype wire

// ===== src/pml_defines.svh
// constants for the per-port phy mmd access and loopback register bank
`ifndef PML_DEFINES_SVH
`define PML_DEFINES_SVH

// ========================================
// register numbers
`define PML_REG_SETUP 5'h0d
`define PML_REG_DATA 5'h0e
`define PML_REG_CAP 5'h0f
`define PML_REG_LOOP 5'h11

// ========================================
// field positions
`define PML_MODE_HI 15
`define PML_MODE_LO 14
`define PML_DEV_HI 4
`define PML_DEV_LO 0
`define PML_SETUP_RSV_HI 13
`define PML_SETUP_RSV_LO 5
`define PML_LOOP_BIT 8
`define PML_LOOP_RC_BIT 1
`define PML_LOOP_RO_BIT 0

// ========================================
// reset and fixed values
`define PML_SETUP_RST 16'h0000
`define PML_DATA_RST 16'h0000
`define PML_CAP_VALUE 16'h3000
`define PML_LOOP_RST 16'h00f4
`define PML_LOOP_WMASK 16'hfffe
`define PML_ZERO16 16'h0000
`define PML_ONE16 16'h0001

// ========================================
// mmd backing store geometry
`define PML_MEM_AW 8
`define PML_MEM_DEPTH 256
`define PML_MEM_DEV_BITS 3
`define PML_MEM_REG_BITS 5

`endif

// ===== src/pml_pkg.sv
// types for the phy mmd access and loopback register bank
package pml_pkg;

	// operation mode of the mmd setup register
	typedef enum logic [1:0] {
		PML_MODE_REG = 2'b00,
		PML_MODE_DATA = 2'b01,
		PML_MODE_INC_RW = 2'b10,
		PML_MODE_INC_WR = 2'b11
	} pml_mode_t;

endpackage

// ===== src/pml_mem_if.sv
// carrier between the register bank and its mmd backing store
`timescale 1ns/1ns
`default_nettype none
`include "pml_defines.svh"

interface pml_mem_if;
	logic we;
	logic [`PML_MEM_AW-1:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;

	modport ctrl (output we, output addr, output wdata, input rdata);
	modport mem (input we, input addr, input wdata, output rdata);
endinterface

`default_nettype wire

// ===== src/pml_mmd_mem.sv
// small single-port store holding mmd register contents
`timescale 1ns/1ns
`default_nettype none
`include "pml_defines.svh"

module pml_mmd_mem (
	// clock
	input wire logic i_clk,
	// access port
	pml_mem_if.mem m
);

	logic [15:0] mem_q [0:`PML_MEM_DEPTH-1];
	logic [15:0] rdata_q;

	// ========================================
	// write, and read through an output register
	always_ff @(posedge i_clk) begin
		if (m.we) begin
			mem_q[m.addr] <= m.wdata;
		end
		rdata_q <= mem_q[m.addr];
	end

	assign m.rdata = rdata_q;

endmodule

`default_nettype wire

// ===== tb/pml_host.sv
// management host model driving the bank's register port
`timescale 1ns/1ns
`default_nettype none
`include "pml_defines.svh"
module pml_host (
	// clock
	input wire logic i_clk,
	// requests
	output logic [4:0] o_addr,
	output logic o_wr,
	output logic o_rd,
	output logic [15:0] o_wdata,
	// answers
	input wire logic [15:0] i_rdata,
	input wire logic i_rvalid
);
	// idle request lines from time zero
	initial begin
		o_addr = 5'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_wdata = 16'h0000;
	end

	// one write; r adds a read strobe in the same cycle
	task automatic wr(input logic [4:0] a, input logic [15:0] d,
		input logic r = 1'b0);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		o_rd <= r;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_rd <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask

	// one read, answer taken while rvalid stands
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		d = 16'hxxxx;
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		repeat (4) begin
			@(negedge i_clk);
			if (i_rvalid === 1'b1) d = i_rdata;
		end
	endtask

	// aim the data register at one mmd register
	task automatic point(input logic [4:0] dev, input logic [15:0] p);
		wr(`PML_REG_SETUP, {2'b00, 9'h000, dev});
		wr(`PML_REG_DATA, p);
	endtask

	// change only the loopback control, keeping the other bits
	task automatic set_loop(input logic on);
		logic [15:0] v;
		rd(`PML_REG_LOOP, v);
		wr(`PML_REG_LOOP, {v[15:9], on, v[7:0]});
	endtask
endmodule
`default_nettype wire

// ===== tb/pml_phy_regs_sva.sv
// port assertions for the phy mmd access and loopback bank
`timescale 1ns/1ns
`default_nettype none
`include "pml_defines.svh"
module pml_phy_regs_sva (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// register port
	input wire logic [4:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [15:0] o_reg_rdata,
	input wire logic o_reg_rvalid,
	// data paths
	input wire logic i_port_is_mii,
	input wire logic [7:0] i_phy_rx_data,
	input wire logic i_phy_rx_dv,
	input wire logic [7:0] o_phy_tx_data,
	input wire logic o_phy_tx_en,
	input wire logic [7:0] i_mii_txd,
	input wire logic i_mii_tx_en,
	input wire logic [7:0] o_mii_rxd,
	input wire logic o_mii_rx_dv,
	input wire logic o_fab_rx_dv,
	input wire logic [7:0] o_fab_rx_data,
	input wire logic [7:0] i_fab_tx_data,
	input wire logic i_fab_tx_en,
	input wire logic o_loopback
);
	// a read that is really taken
	wire logic rd_take = i_reg_rd && !i_reg_wr;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);

	a_read_answer: assert property (rd_take |-> ##2 o_reg_rvalid)
		else $error("read answer not two cycles later");
	a_no_stray: assert property (o_reg_rvalid |-> $past(rd_take, 2))
		else $error("answer without a read");
	a_cap_value: assert property (o_reg_rvalid &&
		$past(i_reg_addr, 2) == `PML_REG_CAP |-> o_reg_rdata == 16'h3000)
		else $error("capability value wrong");
	a_write_wins: assert property (i_reg_wr && i_reg_rd |-> ##2 !o_reg_rvalid)
		else $error("read answered beside a write");
	a_phy_loop: assert property (o_loopback && $past(o_loopback) &&
		!i_port_is_mii && $stable(i_port_is_mii) |->
		o_phy_tx_en == $past(i_phy_rx_dv) &&
		(!o_phy_tx_en || o_phy_tx_data == $past(i_phy_rx_data)))
		else $error("phy receive not returned");
	a_mii_loop: assert property (o_loopback && $past(o_loopback) &&
		i_port_is_mii && $stable(i_port_is_mii) |->
		o_mii_rx_dv == $past(i_mii_tx_en) &&
		(!o_mii_rx_dv || o_mii_rxd == $past(i_mii_txd)))
		else $error("mii transmit not returned");
	a_fab_block: assert property (o_loopback && $past(o_loopback)
		|-> !o_fab_rx_dv)
		else $error("fabric fed during loopback");
	a_fab_pass: assert property (!o_loopback && !$past(o_loopback) &&
		$stable(i_port_is_mii) |-> o_fab_rx_dv == (i_port_is_mii ?
		$past(i_mii_tx_en) : $past(i_phy_rx_dv)))
		else $error("ingress not forwarded");
	a_fab_data: assert property (!o_loopback && o_fab_rx_dv &&
		$stable(i_port_is_mii) |-> o_fab_rx_data == (i_port_is_mii ?
		$past(i_mii_txd) : $past(i_phy_rx_data)))
		else $error("ingress data not forwarded");
	a_fab_egress: assert property (!o_loopback &&
		$stable(i_port_is_mii) |->
		o_phy_tx_en == (!i_port_is_mii && $past(i_fab_tx_en)) &&
		o_mii_rx_dv == (i_port_is_mii && $past(i_fab_tx_en)) &&
		o_phy_tx_data == $past(i_fab_tx_data) &&
		o_mii_rxd == $past(i_fab_tx_data))
		else $error("fabric egress not delivered");
endmodule

bind pml_phy_regs pml_phy_regs_sva u_sva (.i_clk(i_clk), .i_rst(i_rst),
	.i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
	.o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
	.i_port_is_mii(i_port_is_mii), .i_phy_rx_data(i_phy_rx_data),
	.i_phy_rx_dv(i_phy_rx_dv), .o_phy_tx_data(o_phy_tx_data),
	.o_phy_tx_en(o_phy_tx_en), .i_mii_txd(i_mii_txd),
	.i_mii_tx_en(i_mii_tx_en), .o_mii_rxd(o_mii_rxd),
	.o_mii_rx_dv(o_mii_rx_dv), .o_fab_rx_dv(o_fab_rx_dv),
	.o_fab_rx_data(o_fab_rx_data), .i_fab_tx_data(i_fab_tx_data),
	.i_fab_tx_en(i_fab_tx_en),
	.o_loopback(o_loopback));
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the phy mmd access and loopback bank
`timescale 1ns/1ns
`default_nettype none
`include "pml_defines.svh"
module testbench;
	logic i_clk = 0, i_rst = 1, mii = 0, wr, rd, rvalid, lb, rxv = 0;
	logic [4:0] addr;
	logic [15:0] wdata, rdata;
	logic [7:0] rxd = 0, txd = 0, ftd = 0;
	logic txv = 0, ftv = 0;
	logic [15:0] mem [256];
	logic [4:0] ra [5] = '{`PML_REG_SETUP, `PML_REG_DATA, `PML_REG_CAP,
		`PML_REG_LOOP, 5'h10};
	logic [15:0] rv [5] = '{`PML_SETUP_RST, `PML_DATA_RST, `PML_CAP_VALUE,
		`PML_LOOP_RST, `PML_ZERO16};
	int fails = 0, n_tests = 0, cyc = 0;

	pml_host host (.i_clk(i_clk), .o_addr(addr), .o_wr(wr), .o_rd(rd),
		.o_wdata(wdata), .i_rdata(rdata), .i_rvalid(rvalid));
	pml_phy_regs dut (.i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(addr),
		.i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
		.o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_port_is_mii(mii),
		.i_phy_rx_data(rxd), .i_phy_rx_dv(rxv), .o_phy_tx_data(),
		.o_phy_tx_en(), .i_mii_txd(txd), .i_mii_tx_en(txv), .o_mii_rxd(),
		.o_mii_rx_dv(), .o_fab_rx_data(), .o_fab_rx_dv(),
		.i_fab_tx_data(ftd), .i_fab_tx_en(ftv), .o_loopback(lb));

	// clock and hang limit
	initial forever #25 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			fails++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	// pointer after one data access
	function automatic logic [15:0] nxt(input logic [1:0] m,
		input logic [15:0] p, input logic w);
		if (m == 2'b10 || (m == 2'b11 && w)) return p + 16'h0001;
		return p;
	endfunction

	// random frame traffic on all ingress pins for one flavour
	task automatic pump(input logic f);
		repeat (40) begin
			@(posedge i_clk);
			mii <= f;
			{rxd, rxv, txd, txv, ftd, ftv} <= 27'($urandom);
		end
		@(negedge i_clk);
	endtask

	// two writes then two reads in one data mode, pointer checked
	task automatic mmd_run(input logic [1:0] m, input logic [4:0] dev,
		input logic [15:0] p0);
		logic [15:0] p, d, got;
		p = p0;
		host.point(dev, p0);
		host.wr(`PML_REG_SETUP, {m, 9'h000, dev});
		repeat (2) begin
			d = 16'($urandom);
			host.wr(`PML_REG_DATA, d);
			mem[{dev[2:0], p[4:0]}] = d;
			p = nxt(m, p, 1'b1);
		end
		host.wr(`PML_REG_SETUP, {2'b00, 9'h000, dev});
		host.rd(`PML_REG_DATA, got);
		check(got, p);
		host.point(dev, p0);
		host.wr(`PML_REG_SETUP, {m, 9'h000, dev});
		p = p0;
		repeat (2) begin
			host.rd(`PML_REG_DATA, got);
			check(got, mem[{dev[2:0], p[4:0]}]);
			p = nxt(m, p, 1'b0);
		end
		host.wr(`PML_REG_SETUP, {2'b00, 9'h000, dev});
		host.rd(`PML_REG_DATA, got);
		check(got, p);
	endtask

	// main sequence
	initial begin
		logic [15:0] got;
		void'($urandom(32'h0e3b));
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		repeat (2) begin
			for (int i = 0; i < 5; i++) begin
				host.rd(ra[i], got);
				check(got, rv[i]);
			end
			host.wr(`PML_REG_CAP, 16'hffff);
			host.wr(5'h10, 16'hffff);
		end
		host.wr(`PML_REG_SETUP, 16'h4005, 1'b1);
		host.rd(`PML_REG_SETUP, got);
		check(got, 16'h4005);
		for (int k = 0; k < 6; k++)
			mmd_run(2'(k % 3 + 1), 5'($urandom),
				k == 1 ? 16'hffff : 16'($urandom));
		host.wr(`PML_REG_LOOP, 16'hffff);
		host.rd(`PML_REG_LOOP, got);
		check(got, 16'hfffe);
		host.rd(`PML_REG_LOOP, got);
		check(got, 16'hfffc);
		pump(1'b0);
		pump(1'b1);
		check({15'h0000, lb}, 16'h0001);
		host.set_loop(1'b0);
		pump(1'b0);
		pump(1'b1);
		check({15'h0000, lb}, 16'h0000);
		host.rd(`PML_REG_LOOP, got);
		check(got, 16'hfefc);
		stop_test();
	end
endmodule
`default_nettype wire
